// ==== core/dpsc_host.sv ====
// Host-side controller that runs read, write and semaphore cycles on one
// port of an asynchronous dual-port SRAM, one command at a time.
// Each command passes IDLE, SETUP, an optional busy hold, STROBE and
// RECOVER; every strobe, address and data pin leaves a flip-flop in the pin driver stage.
// Assumes pins synchronous to clk_in, a far side that answers within the
// strobe time, and busy_n_in pulled high when no arbiter drives it.
`timescale 1ns/10ps
module dpsc_host (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Command port
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire dpsc_pkg::dpsc_cmd_t req_cmd_in,
  input wire logic [dpsc_pkg::ADDR_W-1:0] req_addr_in,
  input wire logic [dpsc_pkg::DATA_W-1:0] req_wdata_in,
  input wire logic [1:0] req_byte_en_in,
  output logic rsp_valid_out,
  output logic [dpsc_pkg::DATA_W-1:0] rsp_rdata_out,
  // Configuration
  input wire logic master_mode_in,
  // Device pins
  output logic chip_select_n_out,
  output logic semaphore_select_n_out,
  output logic upper_byte_select_n_out,
  output logic lower_byte_select_n_out,
  output logic output_enable_n_out,
  output logic read_write_out,
  output logic [dpsc_pkg::ADDR_W-1:0] addr_out,
  output logic [dpsc_pkg::DATA_W-1:0] data_out,
  output logic data_oe_out,
  input wire logic [dpsc_pkg::DATA_W-1:0] data_in,
  output logic busy_n_out,
  output logic busy_oe_out,
  input wire logic busy_n_in
);

  // ----------------------------------------------------------------
  // Pin bundle and sequencer state
  // ----------------------------------------------------------------
  dpsc_pins_if pins ();

  dpsc_pkg::dpsc_state_t state;
  // Held copy of the taken command
  dpsc_pkg::dpsc_cmd_t cmd;
  logic [dpsc_pkg::ADDR_W-1:0] addr;
  logic [dpsc_pkg::DATA_W-1:0] wdata;
  logic [1:0] byte_en;
  // One counter shared by busy hold, strobe and recovery
  logic [dpsc_pkg::CNT_W-1:0] cnt;
  logic is_write;
  logic is_sem;
  logic busy_seen;
  logic [dpsc_pkg::CNT_W-1:0] strobe_len;

  // ----------------------------------------------------------------
  // Decode of the held command
  // ----------------------------------------------------------------
  // Writes and semaphore writes share one write pulse
  assign is_write = (cmd == dpsc_pkg::DPSC_CMD_WRITE) || (cmd == dpsc_pkg::DPSC_CMD_SEM_WRITE);
  assign is_sem = (cmd == dpsc_pkg::DPSC_CMD_SEM_WRITE) || (cmd == dpsc_pkg::DPSC_CMD_SEM_READ);
  // Slave mode: the arbiter's busy input holds off writes only
  assign busy_seen = !master_mode_in && !busy_n_in && is_write;
  // Output enable stays high in writes, so the short pulse is enough
  assign strobe_len = is_write ? dpsc_pkg::CNT_W'(dpsc_pkg::WPULSE_SHORT_CYC)
                               : dpsc_pkg::CNT_W'(dpsc_pkg::READ_CYC);
  // Ready only in IDLE; a request during a cycle simply waits
  assign req_ready_out = (state == dpsc_pkg::DPSC_IDLE);
  // Host is master of busy never; it only reads it as an input
  // In master mode the device drives busy, so it is ignored here
  assign busy_n_out = 1'b1;
  assign busy_oe_out = 1'b0;

  // ----------------------------------------------------------------
  // Command capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    // Reset leaves a harmless read in the holding register
    if (rst_in) begin
      cmd <= dpsc_pkg::DPSC_CMD_READ;
      addr <= '0;
      wdata <= '0;
      byte_en <= 2'h0;
    end else if (req_valid_in && state == dpsc_pkg::DPSC_IDLE) begin
      cmd <= req_cmd_in;
      // Address captured once, so it cannot move mid-cycle
      addr <= req_addr_in;
      // Semaphore request always carries the bit-zero value given
      wdata <= req_wdata_in;
      // Empty byte mask means the whole word
      byte_en <= (req_byte_en_in == 2'h0) ? 2'h3 : req_byte_en_in;
    end
  end

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    // Reset parks the sequencer in IDLE with the counter clear
    if (rst_in) begin
      state <= dpsc_pkg::DPSC_IDLE;
      cnt <= '0;
    end else begin
      unique case (state)
        // Wait for a command; capture takes it at the same edge
        dpsc_pkg::DPSC_IDLE: begin
          if (req_valid_in) begin
            state <= dpsc_pkg::DPSC_SETUP;
          end
        end
        // Address settles one cycle before any select falls
        // Slave writes under busy go to the hold state first
        dpsc_pkg::DPSC_SETUP: begin
          state <= busy_seen ? dpsc_pkg::DPSC_BUSY_HOLD : dpsc_pkg::DPSC_STROBE;
          cnt <= '0;
        end
        // Busy must stay high for the release time before read/write falls
        dpsc_pkg::DPSC_BUSY_HOLD: begin
          if (busy_n_in) begin
            if (cnt >= dpsc_pkg::CNT_W'(dpsc_pkg::BUSY_RELEASE_CYC - 1)) begin
              state <= dpsc_pkg::DPSC_STROBE;
              cnt <= '0;
            end else begin
              cnt <= cnt + 1'b1;
            end
          end else begin
            cnt <= '0;
          end
        end
        // Pins follow the state one cycle later, so they stand strobe_len
        dpsc_pkg::DPSC_STROBE: begin
          if (cnt >= strobe_len - 1'b1) begin
            state <= dpsc_pkg::DPSC_RECOVER;
            cnt <= '0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        // Gap lets device drivers turn off and covers write-to-read time
        // Read data is taken on the first recovery edge
        dpsc_pkg::DPSC_RECOVER: begin
          if (cnt >= dpsc_pkg::CNT_W'(dpsc_pkg::RECOVER_CYC - 1)) begin
            state <= dpsc_pkg::DPSC_IDLE;
            cnt <= '0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        // Unused codes return to IDLE
        default: begin
          state <= dpsc_pkg::DPSC_IDLE;
          cnt <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin levels from state; read/write falls with address already stable
  // ----------------------------------------------------------------
  always_comb begin
    // Idle levels: deselected, read level, host data released
    pins.chip_select_n = 1'b1;
    pins.semaphore_select_n = 1'b1;
    pins.upper_byte_select_n = 1'b1;
    pins.lower_byte_select_n = 1'b1;
    pins.output_enable_n = 1'b1;
    pins.read_write = 1'b1;
    // Address and data stand all cycle; they change only at read level
    pins.addr = addr;
    pins.wdata = wdata;
    pins.data_drive = 1'b0;
    if (state == dpsc_pkg::DPSC_STROBE) begin
      // RAM: chip select low, semaphore high; semaphore: the reverse
      pins.chip_select_n = is_sem;
      pins.semaphore_select_n = !is_sem;
      // Write lands only in select and byte-select overlap
      pins.upper_byte_select_n = !byte_en[1];
      pins.lower_byte_select_n = !byte_en[0];
      // Reads use select, byte select and output enable together
      pins.output_enable_n = is_write;
      pins.read_write = !is_write;
      // Selects and read/write fall together, device outputs stay off
      pins.data_drive = is_write;
    end
  end

  // ----------------------------------------------------------------
  // Pin register stage
  // ----------------------------------------------------------------
  dpsc_pin_drv u_drv (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pins(pins.drv),
    .chip_select_n_out(chip_select_n_out),
    .semaphore_select_n_out(semaphore_select_n_out),
    .upper_byte_select_n_out(upper_byte_select_n_out),
    .lower_byte_select_n_out(lower_byte_select_n_out),
    .output_enable_n_out(output_enable_n_out),
    .read_write_out(read_write_out),
    .addr_out(addr_out),
    .data_out(data_out),
    .data_oe_out(data_oe_out)
  );

  // ----------------------------------------------------------------
  // Read data captured at end of the strobe; pins lag state by one
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= '0;
    end else begin
      rsp_valid_out <= 1'b0;
      if (state == dpsc_pkg::DPSC_RECOVER && cnt == '0) begin
        rsp_valid_out <= 1'b1;
        // Writes answer zero so old read data never looks fresh
        rsp_rdata_out <= is_write ? '0 : data_in;
      end
    end
  end

endmodule // dpsc_host

// ==== core/dpsc_pkg.sv ====
// Constants and types for the host-side dual-port SRAM port controller.
// Assumes a single 100 MHz clock and one SRAM port driven through its pins.
package dpsc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 14;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------
  // Timing in ns for the slower grade, and in cycles at 100 MHz
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int READ_ACCESS_NS = 55;
  localparam int WRITE_PULSE_WIDTH_NS = 40;
  localparam int WRITE_TURNOFF_DELAY_NS = 25;
  localparam int DATA_SETUP_TIME_NS = 30;
  localparam int OUTPUT_OFF_NS = 15;
  localparam int SEM_WRITE_TO_READ_NS = 10;
  localparam int WRITE_HIGH_AFTER_BUSY_NS = 35;
  localparam int READ_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPULSE_SHORT_CYC = (WRITE_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPULSE_LONG_NS = (WRITE_TURNOFF_DELAY_NS + DATA_SETUP_TIME_NS > WRITE_PULSE_WIDTH_NS) ?
    WRITE_TURNOFF_DELAY_NS + DATA_SETUP_TIME_NS : WRITE_PULSE_WIDTH_NS;
  localparam int WPULSE_LONG_CYC = (WPULSE_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TURNOFF_CYC = (WRITE_TURNOFF_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC = (OUTPUT_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEM_GAP_CYC = (SEM_WRITE_TO_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_RELEASE_CYC = (WRITE_HIGH_AFTER_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;

  // ----------------------------------------------------------------
  // Commands and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DPSC_CMD_READ = 2'h0,
    DPSC_CMD_WRITE = 2'h1,
    DPSC_CMD_SEM_WRITE = 2'h2,
    DPSC_CMD_SEM_READ = 2'h3
  } dpsc_cmd_t;

  typedef enum logic [2:0] {
    DPSC_IDLE = 3'h0,
    DPSC_SETUP = 3'h1,
    DPSC_STROBE = 3'h3,
    DPSC_RECOVER = 3'h2,
    DPSC_BUSY_HOLD = 3'h6
  } dpsc_state_t;

endpackage

// ==== core/dpsc_pins_if.sv ====
// Pin bundle between the sequencer and the pin driver module.
// Assumes both sides share clk_in; active-low strobes named _n.
`timescale 1ns/10ps
interface dpsc_pins_if;
  logic chip_select_n;
  logic semaphore_select_n;
  logic upper_byte_select_n;
  logic lower_byte_select_n;
  logic output_enable_n;
  logic read_write;
  logic [dpsc_pkg::ADDR_W-1:0] addr;
  logic [dpsc_pkg::DATA_W-1:0] wdata;
  logic data_drive;

  modport seq (output chip_select_n, semaphore_select_n, upper_byte_select_n, lower_byte_select_n,
    output_enable_n, read_write, addr, wdata, data_drive);
  modport drv (input chip_select_n, semaphore_select_n, upper_byte_select_n, lower_byte_select_n,
    input output_enable_n, read_write, addr, wdata, data_drive);
endinterface

// ==== core/dpsc_pin_drv.sv ====
// Pin register stage: every strobe, address and data pin leaves a flip-flop.
// Assumes the sequencer keeps strobes legal; this stage only retimes them.
`timescale 1ns/10ps
module dpsc_pin_drv (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Sequencer side
  dpsc_pins_if.drv pins,
  // Device pins
  output logic chip_select_n_out,
  output logic semaphore_select_n_out,
  output logic upper_byte_select_n_out,
  output logic lower_byte_select_n_out,
  output logic output_enable_n_out,
  output logic read_write_out,
  output logic [dpsc_pkg::ADDR_W-1:0] addr_out,
  output logic [dpsc_pkg::DATA_W-1:0] data_out,
  output logic data_oe_out
);

  // ----------------------------------------------------------------
  // Registered pins, all idle (deselected, read level) in reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      chip_select_n_out <= 1'b1;
      semaphore_select_n_out <= 1'b1;
      upper_byte_select_n_out <= 1'b1;
      lower_byte_select_n_out <= 1'b1;
      output_enable_n_out <= 1'b1;
      read_write_out <= 1'b1;
      addr_out <= '0;
      data_out <= '0;
      data_oe_out <= 1'b0;
    end else begin
      chip_select_n_out <= pins.chip_select_n;
      semaphore_select_n_out <= pins.semaphore_select_n;
      upper_byte_select_n_out <= pins.upper_byte_select_n;
      lower_byte_select_n_out <= pins.lower_byte_select_n;
      output_enable_n_out <= pins.output_enable_n;
      read_write_out <= pins.read_write;
      addr_out <= pins.addr;
      data_out <= pins.wdata;
      data_oe_out <= pins.data_drive;
    end
  end

endmodule // dpsc_pin_drv

// ==== verif/dpsc_host_props.sv ====
// Port properties of dpsc_host.
// Assumes sync reset and fixed command latencies in master mode.
`timescale 1ns/10ps
module dpsc_host_props (
  // Clock, reset, command
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire logic req_ready_out,
  input wire dpsc_pkg::dpsc_cmd_t req_cmd_in,
  input wire logic rsp_valid_out,
  input wire logic master_mode_in,
  // Pins
  input wire logic chip_select_n_out,
  input wire logic semaphore_select_n_out,
  input wire logic output_enable_n_out,
  input wire logic read_write_out,
  input wire logic [dpsc_pkg::ADDR_W-1:0] addr_out,
  input wire logic data_oe_out,
  input wire logic busy_oe_out
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  sequence s_take;
    req_valid_in && req_ready_out;
  endsequence
  sequence s_take_rd;
    s_take ##0 req_cmd_in == dpsc_pkg::DPSC_CMD_READ;
  endsequence
  // Slave writes may wait on busy, so only master mode has a fixed answer
  sequence s_take_wr;
    s_take ##0 master_mode_in && req_cmd_in inside {dpsc_pkg::DPSC_CMD_WRITE, dpsc_pkg::DPSC_CMD_SEM_WRITE};
  endsequence
  a_read_latency: assert property (s_take_rd |-> ##9 rsp_valid_out)
    else $error("read answer late or early");
  a_write_latency: assert property (s_take_wr |-> ##7 rsp_valid_out)
    else $error("write answer late or early");
  a_read_rw_high: assert property (!output_enable_n_out |-> read_write_out)
    else $error("output enable during write");
  a_select_exclusive: assert property (chip_select_n_out || semaphore_select_n_out)
    else $error("both selects low");
  a_addr_rw_high: assert property (!$stable(addr_out) |-> read_write_out)
    else $error("address moved in write");
  a_write_oe_off: assert property (!read_write_out |-> output_enable_n_out)
    else $error("write with outputs on");
  a_write_pulse_min: assert property ($fell(read_write_out) |-> !read_write_out [*4])
    else $error("write pulse short");
  a_drive_in_write: assert property (data_oe_out |-> !read_write_out)
    else $error("host drives data outside write");
  a_sem_cs_high: assert property (!semaphore_select_n_out |-> chip_select_n_out)
    else $error("chip select low in semaphore access");
  a_busy_undriven: assert property (!busy_oe_out)
    else $error("host drives busy");
endmodule // dpsc_host_props

bind dpsc_host dpsc_host_props u_props (
  .clk_in(clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
  .req_cmd_in(req_cmd_in), .rsp_valid_out(rsp_valid_out), .master_mode_in(master_mode_in),
  .chip_select_n_out(chip_select_n_out), .semaphore_select_n_out(semaphore_select_n_out),
  .output_enable_n_out(output_enable_n_out), .read_write_out(read_write_out), .addr_out(addr_out),
  .data_oe_out(data_oe_out), .busy_oe_out(busy_oe_out)
);

// ==== verif/dpsc_sram_model.sv ====
// One port of the dual-port SRAM: RAM words and one semaphore flag.
// Assumes host pins change only at clk_in edges; far port idle.
`timescale 1ns/10ps
module dpsc_sram_model #(
  // Mailbox word that raises the far port's flag; plain default
  parameter logic [dpsc_pkg::ADDR_W-1:0] MAILBOX_ADDR = '1
) (
  // Clock and bench control
  input wire logic clk_in,
  input wire logic busy_req_in,
  // Host pins
  input wire logic cs_n_in,
  input wire logic sem_n_in,
  input wire logic ub_n_in,
  input wire logic lb_n_in,
  input wire logic oe_n_in,
  input wire logic rw_in,
  input wire logic [dpsc_pkg::ADDR_W-1:0] addr_in,
  input wire logic [dpsc_pkg::DATA_W-1:0] data_in,
  // Device outputs
  output logic [dpsc_pkg::DATA_W-1:0] data_out,
  output logic busy_n_out,
  output logic far_flag_out
);
  // ----------------------------------------
  // Decode and storage
  // ----------------------------------------
  logic [dpsc_pkg::DATA_W-1:0] mem [0:(1<<dpsc_pkg::ADDR_W)-1];
  logic [dpsc_pkg::DATA_W-1:0] last = '0;
  logic flag = 1'b1;
  logic far_flag = 1'b0;
  logic ram_sel, sem_sel, byte_sel, drive;
  assign ram_sel = !cs_n_in && sem_n_in;
  assign sem_sel = cs_n_in && !sem_n_in;
  assign byte_sel = !ub_n_in || !lb_n_in;
  // Outputs stay off whenever read/write is low
  assign drive = rw_in && !oe_n_in && (sem_sel || (ram_sel && byte_sel));
  // Released bus toggles so a stale value never passes
  assign data_out = !drive ? ~last : sem_sel ? {dpsc_pkg::DATA_W{flag}} : mem[addr_in];
  assign busy_n_out = !busy_req_in;
  assign far_flag_out = far_flag;
  initial begin
    for (int i = 0; i < (1<<dpsc_pkg::ADDR_W); i++) mem[i] = '0;
  end
  // Write only in select and byte overlap; plain always, since the
  // initial block fills the same array
  always @(posedge clk_in) begin
    last <= data_out;
    // Far flag set at the first edge where a RAM write to MAILBOX_ADDR has chip select and read/write both low
    if (!rw_in && !cs_n_in && sem_n_in && addr_in == MAILBOX_ADDR) far_flag <= 1'b1;
    if (!rw_in && byte_sel && sem_sel) flag <= data_in[0];
    if (!rw_in && ram_sel && !ub_n_in) mem[addr_in][15:8] <= data_in[15:8];
    if (!rw_in && ram_sel && !lb_n_in) mem[addr_in][7:0] <= data_in[7:0];
  end
endmodule // dpsc_sram_model

// ==== verif/test_dpsc_host.sv ====
// Self-checking bench: dpsc_host against the SRAM port model.
// Assumes 100 MHz clk_in; stimulus at posedge, sampling at negedge.
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module test_dpsc_host;
  logic clk_in, rst_in, req_valid_in, req_ready_out, rsp_valid_out, master_mode_in;
  dpsc_pkg::dpsc_cmd_t req_cmd_in;
  logic [13:0] req_addr_in, addr;
  logic [15:0] req_wdata_in, rsp_rdata_out, host_data, model_data, pin_data;
  logic [1:0] req_byte_en_in;
  logic cs_n, sem_n, ub_n, lb_n, oe_n, rw, data_oe, busy_n, busy_req, busy_drv_n, busy_oe, far_flag;
  int err_count = 0, checks = 0, cyc = 0;
  assign pin_data = data_oe ? host_data : model_data;
  dpsc_host uut (.clk_in(clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
    .req_cmd_in(req_cmd_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
    .req_byte_en_in(req_byte_en_in), .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out),
    .master_mode_in(master_mode_in), .chip_select_n_out(cs_n), .semaphore_select_n_out(sem_n),
    .upper_byte_select_n_out(ub_n), .lower_byte_select_n_out(lb_n), .output_enable_n_out(oe_n),
    .read_write_out(rw), .addr_out(addr), .data_out(host_data), .data_oe_out(data_oe), .data_in(pin_data),
    .busy_n_out(busy_drv_n), .busy_oe_out(busy_oe), .busy_n_in(busy_n));
  dpsc_sram_model u_model (.clk_in(clk_in), .busy_req_in(busy_req), .cs_n_in(cs_n), .sem_n_in(sem_n),
    .ub_n_in(ub_n), .lb_n_in(lb_n), .oe_n_in(oe_n), .rw_in(rw), .addr_in(addr), .data_in(pin_data),
    .data_out(model_data), .busy_n_out(busy_n), .far_flag_out(far_flag));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic conclude();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One command; latency counted in cycles from the take edge
  task automatic cmd(input dpsc_pkg::dpsc_cmd_t c, input logic [13:0] a, input logic [15:0] d,
    input logic [1:0] be, output logic [15:0] rd, output int lat);
    @(posedge clk_in);
    req_valid_in <= 1'b1;
    req_cmd_in <= c;
    req_addr_in <= a;
    req_wdata_in <= d;
    req_byte_en_in <= be;
    lat = 0;
    do @(negedge clk_in); while (req_ready_out !== 1'b1 && ++lat < 50);
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    lat = 0;
    do begin @(negedge clk_in); lat++; end while (rsp_valid_out !== 1'b1 && lat < 100);
    rd = rsp_rdata_out;
    `CHK(rsp_valid_out, 1'b1)
  endtask
  // Byte-masked writes back to back, then reads
  task automatic t_ram();
    logic [15:0] rd;
    int lat;
    cmd(dpsc_pkg::DPSC_CMD_WRITE, 14'h0005, 16'h1234, 2'h3, rd, lat);
    `CHK(lat, 7)
    cmd(dpsc_pkg::DPSC_CMD_WRITE, 14'h0005, 16'hABCD, 2'h1, rd, lat);
    cmd(dpsc_pkg::DPSC_CMD_WRITE, 14'h0005, 16'hEF99, 2'h2, rd, lat);
    cmd(dpsc_pkg::DPSC_CMD_READ, 14'h0005, 16'h0000, 2'h3, rd, lat);
    `CHK(rd, 16'hEFCD)
    `CHK(lat, 9)
    `CHK(far_flag, 1'b0)
    cmd(dpsc_pkg::DPSC_CMD_WRITE, 14'h3FFF, 16'h55AA, 2'h0, rd, lat);
    `CHK(far_flag, 1'b1)
    cmd(dpsc_pkg::DPSC_CMD_READ, 14'h3FFF, 16'h0000, 2'h0, rd, lat);
    `CHK(rd, 16'h55AA)
    $display("t_ram done");
  endtask
  // Request, read back, release; RAM word 0 untouched
  task automatic t_sem();
    logic [15:0] rd;
    int lat;
    cmd(dpsc_pkg::DPSC_CMD_SEM_WRITE, 14'h0000, 16'hFFFE, 2'h3, rd, lat);
    `CHK(lat, 7)
    cmd(dpsc_pkg::DPSC_CMD_SEM_READ, 14'h0000, 16'h0000, 2'h3, rd, lat);
    `CHK(rd[0], 1'b0)
    cmd(dpsc_pkg::DPSC_CMD_SEM_WRITE, 14'h0000, 16'h0001, 2'h3, rd, lat);
    cmd(dpsc_pkg::DPSC_CMD_SEM_READ, 14'h0000, 16'h0000, 2'h3, rd, lat);
    `CHK(rd[0], 1'b1)
    cmd(dpsc_pkg::DPSC_CMD_READ, 14'h0000, 16'h0000, 2'h3, rd, lat);
    `CHK(rd, 16'h0000)
    $display("t_sem done");
  endtask
  // Slave mode: write held off until busy lifts, reads not held;
  // master mode ignores busy altogether
  task automatic t_slave();
    logic [15:0] rd;
    int lat;
    master_mode_in <= 1'b0;
    busy_req <= 1'b1;
    fork
      cmd(dpsc_pkg::DPSC_CMD_WRITE, 14'h0009, 16'h0F0F, 2'h0, rd, lat);
      begin repeat (12) @(posedge clk_in); busy_req <= 1'b0; end
    join
    // Plain write plus nine busy edges, then the release hold
    `CHK(lat, 16 + dpsc_pkg::BUSY_RELEASE_CYC)
    busy_req <= 1'b1;
    cmd(dpsc_pkg::DPSC_CMD_READ, 14'h0009, 16'h0000, 2'h3, rd, lat);
    `CHK(rd, 16'h0F0F)
    `CHK(lat, 9)
    master_mode_in <= 1'b1;
    cmd(dpsc_pkg::DPSC_CMD_WRITE, 14'h0009, 16'hC3A5, 2'h3, rd, lat);
    `CHK(lat, 7)
    busy_req <= 1'b0;
    cmd(dpsc_pkg::DPSC_CMD_READ, 14'h0009, 16'h0000, 2'h3, rd, lat);
    `CHK(rd, 16'hC3A5)
    $display("t_slave done");
  endtask
  // Mid-run reset: pins go idle, busy stays released, port works again
  task automatic t_reset();
    logic [15:0] rd;
    int lat;
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    `CHK({cs_n, sem_n, ub_n, lb_n, oe_n, rw, data_oe}, 7'h7E)
    `CHK({req_ready_out, rsp_valid_out, busy_drv_n, busy_oe}, 4'hA)
    @(posedge clk_in);
    rst_in <= 1'b0;
    cmd(dpsc_pkg::DPSC_CMD_READ, 14'h3FFF, 16'h0000, 2'h3, rd, lat);
    `CHK(rd, 16'h55AA)
    `CHK(lat, 9)
    $display("t_reset done");
  endtask
  // ----------------------------------------
  // Clock, timeout, main sequence
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // About 170 cycles expected; generous ceiling
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    {rst_in, master_mode_in} = 2'h3;
    {req_valid_in, busy_req} = 2'h0;
    req_cmd_in = dpsc_pkg::DPSC_CMD_READ;
    {req_addr_in, req_wdata_in, req_byte_en_in} = '0;
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    t_ram();
    t_sem();
    t_slave();
    t_reset();
    conclude();
  end
endmodule // test_dpsc_host
